// >>> hdl/counter_consts.vh
// Purpose: Constants shared by the counter command decoder and its channel
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes:   Definitions only
`ifndef COUNTER_CONSTS_VH
`define COUNTER_CONSTS_VH

// ============================================================
// Register byte offsets
`define OFF_COMMAND     12'h000
`define OFF_DATA0       12'h004
`define OFF_DATA1       12'h008
`define OFF_DATA2       12'h00c
`define OFF_STATE0      12'h010
`define OFF_STATE1      12'h014
`define OFF_STATE2      12'h018

// ============================================================
// Command byte fields
`define CMD_SEL_HI      7
`define CMD_SEL_LO      6
`define CMD_FMT_HI      5
`define CMD_FMT_LO      4
`define CMD_MODE_HI     3
`define CMD_MODE_LO     1
`define CMD_BCD_BIT     0
`define CMD_RB_NOCNT    5
`define CMD_RB_NOSTAT   4
`define CMD_RB_SEL0     1

// ============================================================
// Codes
`define SEL_READBACK    2'b11
`define FMT_LATCH       2'b00
`define FMT_LOW         2'b01
`define FMT_HIGH        2'b10
`define FMT_BOTH        2'b11

// ============================================================
// Reset values
`define RST_MODE        3'h0
`define RST_FMT         2'b01
`define RST_BCD         1'b0
`define RST_NULL        1'b1

`endif

// >>> hdl/counter_channel.v
// Purpose: Programmed state and read latches of one counter
// Assumes: Strobes are single-cycle; only latch_cnt and latch_stat can coincide (read-back)
// Notes:   Status latch is read out before the count latch
`include "counter_consts.vh"

module counter_channel (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        cfg_wr,
    input  wire [7:0]  cfg_byte,
    input  wire        latch_cnt,
    input  wire        latch_stat,
    input  wire        rd_pop,
    input  wire [15:0] count_value,
    input  wire        count_out,
    input  wire        count_written,
    input  wire        count_loaded,
    output wire [7:0]  rd_byte,
    output wire [9:0]  state_word
);

    reg [2:0]  mode_reg;
    reg [1:0]  fmt_reg;
    reg        bcd_reg;
    reg        null_reg;
    reg        cnt_latched_reg;
    reg        msb_next_reg;
    reg [15:0] cnt_hold_reg;
    reg        st_latched_reg;
    reg [7:0]  st_hold_reg;

    // ============================================================
    // Mode decode
    // mode normalisation
    function [2:0] mode_of;
        input [2:0] m;
        begin
            mode_of = m[1] ? {1'b0, m[1:0]} : m;
        end
    endfunction

    // ============================================================
    // Control word and latches
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg        <= `RST_MODE;
            fmt_reg         <= `RST_FMT;
            bcd_reg         <= `RST_BCD;
            cnt_latched_reg <= 1'b0;
            msb_next_reg    <= 1'b0;
            cnt_hold_reg    <= 16'h0000;
            st_latched_reg  <= 1'b0;
            st_hold_reg     <= 8'h00;
        end
        else if (cfg_wr)
        begin
            fmt_reg         <= cfg_byte[`CMD_FMT_HI:`CMD_FMT_LO];
            mode_reg        <= mode_of(cfg_byte[`CMD_MODE_HI:`CMD_MODE_LO]);
            bcd_reg         <= cfg_byte[`CMD_BCD_BIT];
            // Reprogramming abandons any half-read latch
            cnt_latched_reg <= 1'b0;
            msb_next_reg    <= 1'b0;
            st_latched_reg  <= 1'b0;
        end
        else
        begin
            if (latch_cnt && !cnt_latched_reg)
            begin
                cnt_hold_reg    <= count_value;
                cnt_latched_reg <= 1'b1;
                msb_next_reg    <= (fmt_reg == `FMT_HIGH);
            end
            if (latch_stat && !st_latched_reg)
            begin
                st_hold_reg    <= {count_out, null_reg, fmt_reg, mode_reg, bcd_reg};
                st_latched_reg <= 1'b1;
            end
            if (rd_pop)
            begin
                if (st_latched_reg)
                    st_latched_reg <= 1'b0;
                else if (cnt_latched_reg)
                begin
                    if (fmt_reg == `FMT_BOTH && !msb_next_reg)
                        msb_next_reg <= 1'b1;
                    else
                    begin
                        cnt_latched_reg <= 1'b0;
                        msb_next_reg    <= 1'b0;
                    end
                end
            end
        end
    end

    // ============================================================
    // Null count flag
    // set wins over clear
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            null_reg <= `RST_NULL;
        else if (cfg_wr || count_written)
            null_reg <= 1'b1;
        else if (count_loaded)
            null_reg <= 1'b0;
    end

    assign rd_byte    = st_latched_reg  ? st_hold_reg :
                        cnt_latched_reg ? (msb_next_reg ? cnt_hold_reg[15:8]
                                                        : cnt_hold_reg[7:0]) :
                        8'h00;
    assign state_word = {st_latched_reg, cnt_latched_reg, null_reg,
                         fmt_reg, mode_reg, bcd_reg, msb_next_reg};

endmodule // counter_channel

// >>> hdl/counter_command_decoder.v
// Purpose: APB command decoder for a three-channel interval counter
// Assumes: Counting elements sit outside; they supply counts and load events
// Notes:   Zero-wait APB slave; unmapped addresses answer with PSLVERR
//          Writes to data and state words are dropped without an error
//          A control word throws away any latch still pending on its counter
//          The read-back reserved bit is not policed; software keeps it zero
//
// Overview of operation
// - Control word bits 7:6 pick counter 0, 1 or 2 (00, 01, 10).
// - Top bits 11 mark a read-back command, never a control word.
// - Bits 5:4 set format: 01 low, 10 high, 11 low then high.
// - Bits 5:4 equal 00 with a counter code means counter latch.
// - Bit 0 one selects BCD counting, zero selects binary.
// - Latch command captures the counter chosen by bits 7:6.
// - Latch command ignores bits 3:0; software writes 5:4 as zero.
// - Read-back latches count when bit 5 low, status when bit 4 low.
// - Null count set on control or count write, cleared on load.
`include "counter_consts.vh"

module counter_command_decoder (
    input  wire        REF_CLK,
    input  wire        RSTN,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire        PREADY,
    output reg  [31:0] PRDATA,
    output wire        PSLVERR,
    // Counting elements
    input  wire [15:0] COUNT_VALUE0,
    input  wire [15:0] COUNT_VALUE1,
    input  wire [15:0] COUNT_VALUE2,
    input  wire [2:0]  COUNT_OUT,
    input  wire [2:0]  COUNT_WRITTEN,
    input  wire [2:0]  COUNT_LOADED,
    // Programmed state, one field per counter
    output wire [8:0]  MODE_ALL,
    output wire [5:0]  FORMAT_ALL,
    output wire [2:0]  BCD_ALL,
    output wire [2:0]  NULL_COUNT
);

    wire        setup_ph;
    wire        access_ph;
    wire [6:0]  reg_hit;
    wire        addr_ok;
    wire        cmd_wr;
    wire [7:0]  cmd;
    wire [1:0]  sel_code;
    wire [1:0]  fmt_code;
    wire        is_readback;
    wire        is_latch;
    wire        is_control;
    wire [2:0]  ctr_hit;
    wire [2:0]  rb_hit;
    wire [2:0]  cfg_wr;
    wire [2:0]  latch_cnt;
    wire [2:0]  latch_stat;
    wire [2:0]  rd_pop;
    wire [47:0] count_bus;
    wire [23:0] rd_bytes;
    wire [29:0] state_words;
    reg  [31:0] rdata_next;
    reg  [31:0] prdata_next;
    reg         err_reg;
    reg         err_next;

    // ============================================================
    // Address decode
    // One-hot register hit, shared by the error flag and the strobes
    // Offsets not listed here answer with PSLVERR
    function [6:0] reg_decode;
        input [11:0] a;
        begin
            reg_decode    = 7'h00;
            reg_decode[0] = (a == `OFF_COMMAND);
            reg_decode[1] = (a == `OFF_DATA0);
            reg_decode[2] = (a == `OFF_DATA1);
            reg_decode[3] = (a == `OFF_DATA2);
            reg_decode[4] = (a == `OFF_STATE0);
            reg_decode[5] = (a == `OFF_STATE1);
            reg_decode[6] = (a == `OFF_STATE2);
        end
    endfunction

    // Counter code to one-hot; code 11 selects none
    function [2:0] ctr_onehot;
        input [1:0] code;
        begin
            case (code)
                2'b00:   ctr_onehot = 3'b001;
                2'b01:   ctr_onehot = 3'b010;
                2'b10:   ctr_onehot = 3'b100;
                default: ctr_onehot = 3'b000;
            endcase
        end
    endfunction

    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign reg_hit   = reg_decode(PADDR);
    assign addr_ok   = |reg_hit;
    // Always ready: every register answers in the first access cycle
    assign PREADY    = 1'b1;
    assign PSLVERR   = access_ph && err_reg;

    // ============================================================
    // Command decode
    assign cmd_wr      = access_ph && PWRITE && reg_hit[0];
    assign cmd         = PWDATA[7:0];
    assign sel_code    = cmd[`CMD_SEL_HI:`CMD_SEL_LO];
    assign fmt_code    = cmd[`CMD_FMT_HI:`CMD_FMT_LO];
    assign is_readback = (sel_code == `SEL_READBACK);
    assign is_latch    = !is_readback && (fmt_code == `FMT_LATCH);
    assign is_control  = !is_readback && (fmt_code != `FMT_LATCH);
    assign ctr_hit     = ctr_onehot(sel_code);
    // Bit 0 of read-back is not checked; software keeps it zero
    // reserved bit unused
    assign rb_hit      = cmd[`CMD_RB_SEL0+2:`CMD_RB_SEL0];

    assign cfg_wr    = {3{cmd_wr && is_control}} & ctr_hit;
    // latch target; counter latch ignores bits 3:0, read-back term uses bits 3:1
    assign latch_cnt = ({3{cmd_wr && is_latch}} & ctr_hit) |
                       ({3{cmd_wr && is_readback && !cmd[`CMD_RB_NOCNT]}} & rb_hit);
    assign latch_stat = {3{cmd_wr && is_readback && !cmd[`CMD_RB_NOSTAT]}} & rb_hit;

    // Data register reads pop one byte from the latch
    assign rd_pop = {3{access_ph && !PWRITE}} &
                    reg_hit[3:1];

    assign count_bus = {COUNT_VALUE2, COUNT_VALUE1, COUNT_VALUE0};

    // ============================================================
    // Channels
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : ch
            counter_channel u_chan (
                .clk           (REF_CLK),
                .rst_n         (RSTN),
                .cfg_wr        (cfg_wr[g]),
                .cfg_byte      (cmd),
                .latch_cnt     (latch_cnt[g]),
                .latch_stat    (latch_stat[g]),
                .rd_pop        (rd_pop[g]),
                .count_value   (count_bus[16*g+15:16*g]),
                .count_out     (COUNT_OUT[g]),
                .count_written (COUNT_WRITTEN[g]),
                .count_loaded  (COUNT_LOADED[g]),
                .rd_byte       (rd_bytes[8*g+7:8*g]),
                .state_word    (state_words[10*g+9:10*g])
            );
        end
    endgenerate

    // ============================================================
    // Programmed state outputs
    // Fields come straight from the channel flops, no extra delay
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : fld
            assign MODE_ALL[3*g+2:3*g]   = state_words[10*g+4:10*g+2];
            assign FORMAT_ALL[2*g+1:2*g] = state_words[10*g+6:10*g+5];
            assign BCD_ALL[g]            = state_words[10*g+1];
            assign NULL_COUNT[g]         = state_words[10*g+7];
        end
    endgenerate

    // ============================================================
    // Read data
    // Captured in the setup cycle so the bus sees flop outputs
    always @*
    begin
        rdata_next = 32'h0000_0000;
        case (PADDR)
            `OFF_DATA0:  rdata_next = {24'h00_0000, rd_bytes[7:0]};
            `OFF_DATA1:  rdata_next = {24'h00_0000, rd_bytes[15:8]};
            `OFF_DATA2:  rdata_next = {24'h00_0000, rd_bytes[23:16]};
            `OFF_STATE0: rdata_next = {22'h0, state_words[9:0]};
            `OFF_STATE1: rdata_next = {22'h0, state_words[19:10]};
            `OFF_STATE2: rdata_next = {22'h0, state_words[29:20]};
            default:     rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data and error flag change only at the end of a setup cycle,
    // so both stand unchanged through the access cycle
    always @*
    begin
        prdata_next = PRDATA;
        err_next    = err_reg;
        if (setup_ph)
        begin
            prdata_next = PWRITE ? 32'h0000_0000 : rdata_next;
            err_next    = !addr_ok;
        end
    end

    always @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PRDATA  <= 32'h0000_0000;
            err_reg <= 1'b0;
        end
        else
        begin
            PRDATA  <= prdata_next;
            err_reg <= err_next;
        end
    end

endmodule // counter_command_decoder

// >>> tb/counter_command_decoder_assertions.sv
// Purpose: Port assertions for the counter command decoder
// Assumes: Zero-wait APB slave, command port at byte address 0
// Notes:   Bound to the design from the tb file
module counter_command_decoder_checker (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [2:0]  COUNT_WRITTEN,
    input wire logic [2:0]  COUNT_LOADED,
    input wire logic [8:0]  MODE_ALL,
    input wire logic [5:0]  FORMAT_ALL,
    input wire logic [2:0]  BCD_ALL,
    input wire logic [2:0]  NULL_COUNT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // ============================================================
    // Helpers
    logic       wr;
    logic [7:0] b;
    logic [7:0] b_q;
    logic [2:0] clr_q;
    assign b  = PWDATA[7:0];
    assign wr = PSEL && PENABLE && PWRITE && (PADDR == 12'h000);
    // Keep the command one cycle so the check sees its own cause
    always_ff @(posedge REF_CLK)
    begin
        b_q   <= b;
        clr_q <= COUNT_LOADED & ~COUNT_WRITTEN & {3{!wr}};
    end
    function automatic logic [2:0] mexp(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction
    // ============================================================
    // Properties
    sequence s_cw;
        wr && b[7:6] != 2'b11 && b[5:4] != 2'b00;
    endsequence
    sequence s_other;
        wr && (b[7:6] == 2'b11 || b[5:4] == 2'b00);
    endsequence
    property p_cw_fmt;
        s_cw |=> FORMAT_ALL[2*b_q[7:6] +: 2] == b_q[5:4];
    endproperty
    property p_cw_mode;
        s_cw |=> MODE_ALL[3*b_q[7:6] +: 3] == mexp(b_q[3:1]);
    endproperty
    property p_cw_bcd;
        s_cw |=> BCD_ALL[b_q[7:6]] == b_q[0];
    endproperty
    property p_cw_null;
        s_cw |=> NULL_COUNT[b_q[7:6]];
    endproperty
    property p_cmd_keep;
        s_other |=> $stable(MODE_ALL) && $stable(FORMAT_ALL) && $stable(BCD_ALL);
    endproperty
    property p_null_set;
        COUNT_WRITTEN != 3'b000 |=> (NULL_COUNT & $past(COUNT_WRITTEN)) == $past(COUNT_WRITTEN);
    endproperty
    property p_null_clr;
        clr_q != 3'b000 |-> (NULL_COUNT & clr_q) == 3'b000;
    endproperty
    property p_ready;
        PSEL |-> PREADY;
    endproperty
    property p_unmapped;
        PSEL && PENABLE && PADDR > 12'h018 |-> PSLVERR;
    endproperty
    a_cw_fmt: assert property (p_cw_fmt)
        else $error("format not taken from control word");
    a_cw_mode: assert property (p_cw_mode)
        else $error("mode not decoded from control word");
    a_cw_bcd: assert property (p_cw_bcd)
        else $error("bcd select not taken from control word");
    a_cw_null: assert property (p_cw_null)
        else $error("null flag not set by control word");
    a_cmd_keep: assert property (p_cmd_keep)
        else $error("latch or read-back changed programming");
    a_null_set: assert property (p_null_set)
        else $error("null flag not set by count write");
    a_null_clr: assert property (p_null_clr)
        else $error("null flag not cleared by load");
    a_ready: assert property (p_ready)
        else $error("ready low during select");
    a_unmapped: assert property (p_unmapped)
        else $error("no error on unmapped address");
endmodule // counter_command_decoder_checker

// >>> tb/tb.sv
// Purpose: Self-checking bench for the counter command decoder
// Assumes: Zero-wait APB slave, commands written at byte address 0
// Notes:   Bench drives count and load events in place of counting elements
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        REF_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [15:0] COUNT_VALUE0 = 16'h0;
    logic [15:0] COUNT_VALUE1 = 16'h0;
    logic [15:0] COUNT_VALUE2 = 16'h0;
    logic [2:0]  COUNT_OUT = 3'h0;
    logic [2:0]  COUNT_WRITTEN = 3'h0;
    logic [2:0]  COUNT_LOADED = 3'h0;
    wire         PREADY;
    wire         PSLVERR;
    wire  [31:0] PRDATA;
    wire  [8:0]  MODE_ALL;
    wire  [5:0]  FORMAT_ALL;
    wire  [2:0]  BCD_ALL;
    wire  [2:0]  NULL_COUNT;
    logic [31:0] rd;
    logic        er;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          n;
    always #5 REF_CLK = ~REF_CLK;
    counter_command_decoder uut (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .COUNT_VALUE0(COUNT_VALUE0),
        .COUNT_VALUE1(COUNT_VALUE1), .COUNT_VALUE2(COUNT_VALUE2), .COUNT_OUT(COUNT_OUT),
        .COUNT_WRITTEN(COUNT_WRITTEN), .COUNT_LOADED(COUNT_LOADED), .MODE_ALL(MODE_ALL),
        .FORMAT_ALL(FORMAT_ALL), .BCD_ALL(BCD_ALL), .NULL_COUNT(NULL_COUNT));
    // ============================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request held until ready is sampled high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge REF_CLK);
            if (PREADY === 1'b1) break;
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (k == 16)
        begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic pulse(input logic [2:0] ld, input logic [2:0] wr);
        @(posedge REF_CLK);
        COUNT_LOADED <= ld;
        COUNT_WRITTEN <= wr;
        @(posedge REF_CLK);
        COUNT_LOADED <= 3'h0;
        COUNT_WRITTEN <= 3'h0;
        #1;
    endtask
    // ============================================================
    // Sequence
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        RSTN <= 1'b1;
        for (n = 0; n < 3; n++) rdc(12'h010 + 12'(4*n), 32'h0a0);
        check({MODE_ALL, FORMAT_ALL, BCD_ALL, NULL_COUNT}, {9'h0, 6'h15, 6'h7});
        pulse(3'b111, 3'b000);
        check(NULL_COUNT, 3'b000);
        pulse(3'b001, 3'b001);
        check(NULL_COUNT, 3'b001);
        // Every mode code, spread over all counters and formats
        for (n = 0; n < 8; n++)
        begin
            apb(1'b1, 12'h000, {24'h0, 2'(n % 3), 2'(n % 3 + 1), 3'(n), 1'(n)});
            #1;
            check(MODE_ALL[3*(n%3) +: 3], (n[1] ? n[1:0] : n[2:0]));
            check(FORMAT_ALL[2*(n%3) +: 2], n % 3 + 1);
            check({BCD_ALL[n%3], NULL_COUNT[n%3]}, {n[0], 1'b1});
        end
        @(posedge REF_CLK) COUNT_VALUE1 <= 16'h1234;
        apb(1'b1, 12'h000, 32'h74);
        apb(1'b1, 12'h000, 32'h4f);
        #1 check({MODE_ALL[5:3], BCD_ALL[1]}, 4'h4);
        @(posedge REF_CLK) COUNT_VALUE1 <= 16'h5678;
        apb(1'b1, 12'h000, 32'h40);
        rdc(12'h008, 32'h34);
        rdc(12'h008, 32'h12);
        rdc(12'h008, 32'h00);
        apb(1'b1, 12'h000, 32'h40);
        rdc(12'h008, 32'h78);
        @(posedge REF_CLK) COUNT_VALUE2 <= 16'habcd;
        COUNT_OUT <= 3'b100;
        apb(1'b1, 12'h000, 32'h96);
        pulse(3'b100, 3'b000);
        apb(1'b1, 12'h000, 32'hc8);
        #1 check(MODE_ALL[8:6], 3'h3);
        rdc(12'h00c, 32'h96);
        rdc(12'h00c, 32'hcd);
        rdc(12'h00c, 32'h00);
        apb(1'b1, 12'h000, 32'he8);
        rdc(12'h00c, 32'h96);
        rdc(12'h00c, 32'h00);
        apb(1'b1, 12'h000, 32'hd8);
        rdc(12'h00c, 32'hcd);
        @(posedge REF_CLK) COUNT_VALUE0 <= 16'h5a3c;
        apb(1'b1, 12'h000, 32'h00);
        rdc(12'h004, 32'h3c);
        apb(1'b1, 12'h000, 32'he6);
        rdc(12'h004, 32'h54);
        rdc(12'h008, 32'h74);
        rdc(12'h008, 32'h56);
        rdc(12'h008, 32'h00);
        rdc(12'h000, 32'h0);
        rdc(12'h01c, 32'h0);
        check(er, 1'b1);
        apb(1'b1, 12'h100, 32'h55);
        check(er, 1'b1);
        finish_test();
    end
endmodule // tb

bind counter_command_decoder counter_command_decoder_checker u_chk (.REF_CLK(REF_CLK),
    .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COUNT_WRITTEN(COUNT_WRITTEN),
    .COUNT_LOADED(COUNT_LOADED), .MODE_ALL(MODE_ALL), .FORMAT_ALL(FORMAT_ALL),
    .BCD_ALL(BCD_ALL), .NULL_COUNT(NULL_COUNT));
